// ===== hw/dies_pkg.sv
package dies_pkg;

    localparam int          ADDR_W            = 15;
    localparam int          DATA_W            = 8;
    localparam int          SRC_W             = 5;
    localparam int          CNT_W             = 5;

    // register map
    localparam logic [14:0] OFF_ENABLES       = 15'h0020;
    localparam logic [14:0] OFF_FLAGS         = 15'h0024;
    localparam logic [4:0]  RST_ENABLES       = 5'h00;
    localparam logic [4:0]  RST_FLAGS         = 5'h00;
    localparam logic [2:0]  RESERVED_READ     = 3'h0;
    localparam logic [7:0]  UNMAPPED_READ     = 8'h00;

    // bit positions shared by both registers
    localparam int          BIT_TIMING_JITTER = 4;
    localparam int          BIT_LINK_READY    = 3;
    localparam int          BIT_LANE_FIFO     = 2;
    localparam int          BIT_IMAG_PATTERN  = 1;
    localparam int          BIT_REAL_PATTERN  = 0;

    // serial frame: read flag, 15 address bits, 8 data bits
    localparam logic [4:0]  HDR_BITS          = 5'h10;
    localparam logic [4:0]  FRAME_BITS        = 5'h18;
    localparam int          RW_POS            = 14;

    typedef struct packed {
        logic                    write;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       wdata;
    } dies_access_type;

    typedef struct packed {
        logic timing_jitter_event;
        logic receiver_link_ready;
        logic lane_fifo_error;
        logic imag_pattern_error;
        logic real_pattern_error;
    } dies_event_type;

endpackage : dies_pkg

// ===== hw/dies_spi_port.sv
`timescale 1ns/1ps
module dies_spi_port
(
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     sclk,
    input  wire logic                     cs_b,
    input  wire logic                     sdi,
    input  wire logic [7:0]               rdata,
    output logic                          sdo,
    output logic                          sdo_oe_b,
    output dies_pkg::dies_access_type     access
);
    // pins are asynchronous to clk; sclk must stay below a quarter of clk
    logic [2:0]                  pin_meta;
    logic [2:0]                  pin_sync;
    logic                        sclk_prev;
    logic [4:0]                  cnt;
    logic [4:0]                  next_cnt;
    logic [15:0]                 in_shift;
    logic [15:0]                 next_in_shift;
    logic [7:0]                  out_shift;
    logic [7:0]                  next_out_shift;
    logic                        is_read;
    logic                        next_is_read;
    logic                        next_sdo;
    logic                        next_sdo_oe_b;
    dies_pkg::dies_access_type   next_access;
    logic                        rise;
    logic                        fall;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_meta  <= 3'h7;
            pin_sync  <= 3'h7;
            sclk_prev <= 1'b1;
        end
        else
        begin
            pin_meta  <= {sclk, cs_b, sdi};
            pin_sync  <= pin_meta;
            sclk_prev <= pin_sync[2];
        end
    end

    assign rise = pin_sync[2] & ~sclk_prev;
    assign fall = ~pin_sync[2] & sclk_prev;

    always_comb
    begin
        next_cnt       = cnt;
        next_in_shift  = in_shift;
        next_out_shift = out_shift;
        next_is_read   = is_read;
        next_sdo       = sdo;
        next_sdo_oe_b  = sdo_oe_b;
        next_access    = access;
        next_access.write = 1'b0;
        if (pin_sync[1])
        begin
            // deselect aborts any partial frame; nothing is written
            next_cnt      = 5'h00;
            next_is_read  = 1'b0;
            next_sdo_oe_b = 1'b1;
        end
        else
        begin
            if (rise && cnt < dies_pkg::FRAME_BITS)
            begin
                next_in_shift = {in_shift[14:0], pin_sync[0]};
                next_cnt      = 5'(cnt + 5'h01);
                if (cnt == 5'(dies_pkg::HDR_BITS - 5'h01))
                begin
                    next_access.addr = {in_shift[13:0], pin_sync[0]};
                    next_is_read     = in_shift[dies_pkg::RW_POS];
                end
                if (cnt == 5'(dies_pkg::FRAME_BITS - 5'h01) && !is_read)
                begin
                    next_access.write = 1'b1;
                    next_access.wdata = {in_shift[6:0], pin_sync[0]};
                end
            end
            if (fall && is_read)
            begin
                if (cnt == dies_pkg::HDR_BITS)
                begin
                    next_sdo       = rdata[7];
                    next_out_shift = {rdata[6:0], 1'b0};
                    next_sdo_oe_b  = 1'b0;
                end
                else if (cnt > dies_pkg::HDR_BITS && cnt < dies_pkg::FRAME_BITS)
                begin
                    next_sdo       = out_shift[7];
                    next_out_shift = {out_shift[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt       <= 5'h00;
            in_shift  <= 16'h0000;
            out_shift <= 8'h00;
            is_read   <= 1'b0;
            sdo       <= 1'b0;
            sdo_oe_b  <= 1'b1;
            access    <= '0;
        end
        else
        begin
            cnt       <= next_cnt;
            in_shift  <= next_in_shift;
            out_shift <= next_out_shift;
            is_read   <= next_is_read;
            sdo       <= next_sdo;
            sdo_oe_b  <= next_sdo_oe_b;
            access    <= next_access;
        end
    end

endmodule : dies_spi_port

// ===== hw/dies_irq_core.sv
// Summary of operation
// - enable bit 4 allows timing jitter interrupt
// - enable bit 3 allows link-ready-low interrupt
// - enable bit 2 allows lane FIFO interrupt
// - enable bit 1 allows imaginary pattern interrupt
// - enable bit 0 allows real pattern interrupt
// - jitter sets sticky flag 4, write-one clears
// - link ready low sets sticky flag 3
// - FIFO sets flag 2, imaginary error flag 1
// - real pattern error sets sticky flag 0
`timescale 1ns/1ps
module dies_irq_core
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    sclk,
    input  wire logic                    cs_b,
    input  wire logic                    sdi,
    input  dies_pkg::dies_event_type     events,
    output logic                         sdo,
    output logic                         sdo_oe_b,
    output logic                         irq
);
    dies_pkg::dies_access_type   access;
    logic [4:0]                  enables;
    logic [4:0]                  next_enables;
    logic [4:0]                  flags;
    logic [4:0]                  next_flags;
    logic [7:0]                  rdata;
    logic [7:0]                  next_rdata;
    logic                        next_irq;
    logic [4:0]                  set_vec;
    logic [4:0]                  clr_vec;
    logic                        wr_enables;
    logic                        wr_flags;

    dies_spi_port u_spi
    (
        .clk      (clk),
        .rst_b    (rst_b),
        .sclk     (sclk),
        .cs_b     (cs_b),
        .sdi      (sdi),
        .rdata    (rdata),
        .sdo      (sdo),
        .sdo_oe_b (sdo_oe_b),
        .access   (access)
    );

    assign wr_enables = access.write && access.addr == dies_pkg::OFF_ENABLES;
    assign wr_flags   = access.write && access.addr == dies_pkg::OFF_FLAGS;

    always_comb
    begin
        set_vec = 5'h00;
        set_vec[dies_pkg::BIT_TIMING_JITTER] = events.timing_jitter_event;
        set_vec[dies_pkg::BIT_LINK_READY]    = ~events.receiver_link_ready;
        set_vec[dies_pkg::BIT_LANE_FIFO]     = events.lane_fifo_error;
        set_vec[dies_pkg::BIT_IMAG_PATTERN]  = events.imag_pattern_error;
        set_vec[dies_pkg::BIT_REAL_PATTERN]  = events.real_pattern_error;
        clr_vec      = wr_flags ? access.wdata[4:0] : 5'h00;
        next_enables = enables;
        if (wr_enables)
        begin
            next_enables = access.wdata[4:0];
        end
        // zeros leave flags; set beats a same-cycle clear
        next_flags = (flags & ~clr_vec) | set_vec;
        case (access.addr)
            dies_pkg::OFF_ENABLES: next_rdata = {dies_pkg::RESERVED_READ, enables};
            dies_pkg::OFF_FLAGS:   next_rdata = {dies_pkg::RESERVED_READ, flags};
            default:               next_rdata = dies_pkg::UNMAPPED_READ;
        endcase
        next_irq = |(flags & enables);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            enables <= dies_pkg::RST_ENABLES;
            flags   <= dies_pkg::RST_FLAGS;
            rdata   <= dies_pkg::UNMAPPED_READ;
            irq     <= 1'b0;
        end
        else
        begin
            enables <= next_enables;
            flags   <= next_flags;
            rdata   <= next_rdata;
            irq     <= next_irq;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_enable_write;
        wr_enables;
    endsequence

    sequence s_flag_held(int b);
        flags[b] && !(wr_flags && access.wdata[b]);
    endsequence

    property p_jitter_enable;
        s_enable_write |=> enables[dies_pkg::BIT_TIMING_JITTER] == $past(access.wdata[4]);
    endproperty
    a_jitter_enable: assert property (p_jitter_enable)
        else $error("jitter enable not stored");

    property p_link_enable;
        s_enable_write ##1 (!wr_enables)[*2] |-> enables[3] == $past(access.wdata[3], 2);
    endproperty
    a_link_enable: assert property (p_link_enable)
        else $error("link enable not held");

    property p_fifo_enable;
        !wr_enables |=> $stable(enables[2]);
    endproperty
    a_fifo_enable: assert property (p_fifo_enable)
        else $error("fifo enable moved without write");

    property p_imag_enable;
        (s_enable_write and access.wdata[1]) |=> enables[1];
    endproperty
    a_imag_enable: assert property (p_imag_enable)
        else $error("imaginary enable not set");

    property p_real_enable_gate;
        (flags[0] && !enables[0] && flags[4:1] == 4'h0) |=> !irq;
    endproperty
    a_real_enable_gate: assert property (p_real_enable_gate)
        else $error("disabled real source raised request");

    property p_jitter_sticky;
        events.timing_jitter_event ##1 s_flag_held(4) |=> flags[4];
    endproperty
    a_jitter_sticky: assert property (p_jitter_sticky)
        else $error("jitter flag lost");

    property p_link_low;
        !events.receiver_link_ready |=> flags[3] && rdata[7:5] == 3'h0;
    endproperty
    a_link_low: assert property (p_link_low)
        else $error("link ready low not flagged");

    property p_fifo_imag;
        (events.lane_fifo_error || events.imag_pattern_error) |=>
            (flags[2] || !$past(events.lane_fifo_error))
            && (flags[1] || !$past(events.imag_pattern_error));
    endproperty
    a_fifo_imag: assert property (p_fifo_imag)
        else $error("fifo or imaginary flag missed");

    property p_real_clear;
        (flags[0] && wr_flags && access.wdata[0] && !events.real_pattern_error)
            |=> !flags[0];
    endproperty
    a_real_clear: assert property (p_real_clear)
        else $error("real flag not cleared by one");

    property p_irq_follow;
        (|(flags & enables)) |=> irq;
    endproperty
    a_irq_follow: assert property (p_irq_follow)
        else $error("request missing for enabled flag");

    property p_zero_write_keeps;
        (wr_flags && access.wdata[4:0] == 5'h00) |=> flags == ($past(flags) | $past(set_vec));
    endproperty
    a_zero_write_keeps: assert property (p_zero_write_keeps)
        else $error("writing zero changed a flag");

    property p_enable_store;
        s_enable_write |=> enables == $past(access.wdata[4:0]);
    endproperty
    a_enable_store: assert property (p_enable_store)
        else $error("enable byte not stored");

    property p_jitter_clear;
        (flags[4] && wr_flags && access.wdata[4] && !events.timing_jitter_event) |=> !flags[4];
    endproperty
    a_jitter_clear: assert property (p_jitter_clear)
        else $error("jitter flag not cleared by one");

    property p_link_set_wins;
        (wr_flags && access.wdata[3] && !events.receiver_link_ready) |=> flags[3];
    endproperty
    a_link_set_wins: assert property (p_link_set_wins)
        else $error("link flag cleared while ready low");

    property p_fifo_clear;
        (flags[2] && wr_flags && access.wdata[2] && !events.lane_fifo_error) |=> !flags[2];
    endproperty
    a_fifo_clear: assert property (p_fifo_clear)
        else $error("fifo flag not cleared by one");

    property p_imag_clear;
        (flags[1] && wr_flags && access.wdata[1] && !events.imag_pattern_error) |=> !flags[1];
    endproperty
    a_imag_clear: assert property (p_imag_clear)
        else $error("imaginary flag not cleared by one");

    property p_irq_quiet;
        !(|(flags & enables)) |=> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet)
        else $error("request without enabled flag");

    property p_unmapped_read;
        (access.addr != dies_pkg::OFF_ENABLES && access.addr != dies_pkg::OFF_FLAGS)
            |=> rdata == dies_pkg::UNMAPPED_READ;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped address read not zero");

endmodule : dies_irq_core

// ===== testbench/tb_dies_irq_core.sv
`timescale 1ns/1ps
module tb_dies_irq_core;
    logic                     clk;
    logic                     rst_b;
    logic                     sclk;
    logic                     cs_b;
    logic                     sdi;
    dies_pkg::dies_event_type events;
    logic                     sdo;
    logic                     sdo_oe_b;
    logic                     irq;
    int                       failures = 0;
    int                       samples_checked = 0;
    int                       nrise = 0;
    logic [7:0]               expq[$];
    logic [7:0]               cap;
    logic [7:0]               en;
    logic [4:0]               mask;
    logic                     oe_ok;
    logic                     is_rd;
    // link ready idles high; low is the event
    localparam logic [4:0]    IDLE_EV = 5'h08;

    dies_irq_core DUT
    (
        .clk      (clk),
        .rst_b    (rst_b),
        .sclk     (sclk),
        .cs_b     (cs_b),
        .sdi      (sdi),
        .events   (events),
        .sdo      (sdo),
        .sdo_oe_b (sdo_oe_b),
        .irq      (irq)
    );

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic check_bit(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    // each sclk level held 4 clk, above the 3 clk sync need
    task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] data,
                         input int nbits);
        logic [23:0] word;
        word = {rd, addr, data};
        @(posedge clk);
        cs_b <= 1'b0;
        for (int i = 23; i > 23 - nbits; i--)
        begin
            @(posedge clk);
            sclk <= 1'b0;
            sdi  <= word[i];
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
        end
        repeat (6) @(posedge clk);
        cs_b <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : frame

    task automatic wr(input logic [14:0] addr, input logic [7:0] data);
        frame(1'b0, addr, data, 24);
    endtask : wr

    task automatic rd(input logic [14:0] addr, input logic [7:0] exp);
        expq.push_back(exp);
        frame(1'b1, addr, 8'h00, 24);
    endtask : rd

    task automatic pulse(input logic [4:0] m);
        @(posedge clk);
        events <= IDLE_EV ^ m;
        @(posedge clk);
        events <= IDLE_EV;
        repeat (3) @(posedge clk);
    endtask : pulse

    task automatic report_and_stop();
        // a read that never completed leaves its note behind
        if (expq.size() != 0)
        begin
            failures++;
            $display("wrong value pending reads expected 0 seen %0d", expq.size());
        end
        if (failures == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // read bytes arrive on rises 17..24 with sdo enabled
    always @(negedge cs_b)
    begin
        nrise = 0;
        oe_ok = 1'b1;
    end

    always @(posedge sclk)
        if (cs_b === 1'b0)
        begin
            nrise++;
            if (nrise == 1)
                is_rd = sdi;
            if (nrise > 16)
            begin
                cap   = {cap[6:0], sdo};
                oe_ok = oe_ok & (sdo_oe_b === 1'b0);
            end
        end

    always @(posedge cs_b)
        if (nrise == 24 && is_rd === 1'b1 && expq.size() > 0)
        begin
            check_byte("read data", expq.pop_front(), cap);
            check_bit("sdo enable", 1'b1, oe_ok);
        end

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // whole run needs about 8.6k clk
    initial
    begin
        repeat (40000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    initial
    begin
        rst_b  = 1'b0;
        sclk   = 1'b0;
        cs_b   = 1'b1;
        sdi    = 1'b0;
        events = IDLE_EV;
        en     = $urandom(32'h265382b8);
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rd(dies_pkg::OFF_ENABLES, 8'h00);
        rd(dies_pkg::OFF_FLAGS, 8'h00);
        check_bit("irq", 1'b0, irq);
        en = 8'($urandom);
        wr(dies_pkg::OFF_ENABLES, en);
        rd(dies_pkg::OFF_ENABLES, en & 8'h1f);
        // one source at a time: set, zero-write, one-write clear
        for (int i = 0; i < 5; i++)
        begin
            pulse(5'h01 << i);
            rd(dies_pkg::OFF_FLAGS, 8'h01 << i);
            check_bit("irq", en[i], irq);
            wr(dies_pkg::OFF_FLAGS, 8'h00);
            rd(dies_pkg::OFF_FLAGS, 8'h01 << i);
            wr(dies_pkg::OFF_FLAGS, 8'h01 << i);
            rd(dies_pkg::OFF_FLAGS, 8'h00);
            check_bit("irq", 1'b0, irq);
        end
        mask = 5'($urandom) | 5'h01;
        pulse(mask);
        wr(dies_pkg::OFF_ENABLES, 8'hff);
        rd(dies_pkg::OFF_FLAGS, {3'h0, mask});
        check_bit("irq", 1'b1, irq);
        wr(dies_pkg::OFF_ENABLES, 8'h00);
        check_bit("irq", 1'b0, irq);
        wr(dies_pkg::OFF_FLAGS, 8'hff);
        rd(dies_pkg::OFF_FLAGS, 8'h00);
        // link held low: set wins over write-one clear
        events <= IDLE_EV ^ 5'h08;
        wr(dies_pkg::OFF_FLAGS, 8'h08);
        rd(dies_pkg::OFF_FLAGS, 8'h08);
        events <= IDLE_EV;
        wr(dies_pkg::OFF_FLAGS, 8'h08);
        rd(dies_pkg::OFF_FLAGS, 8'h00);
        // unmapped place and a cut-short frame change nothing
        wr(15'h0021, 8'hff);
        rd(15'h0021, 8'h00);
        frame(1'b0, dies_pkg::OFF_ENABLES, 8'h15, 20);
        rd(dies_pkg::OFF_ENABLES, 8'h00);
        report_and_stop();
    end
endmodule : tb_dies_irq_core
